// *** design/sst_pkg.sv ***
// shared constants and types of the soft-start / stop timing block
package sst_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RAMP = 8'h61;
  localparam logic [7:0] CMD_LIMIT = 8'h62;
  localparam logic [7:0] CMD_ACTION = 8'h63;
  localparam logic [7:0] CMD_STOP = 8'h64;

  // ----------------------------------------------------------------
  // linear word layout and reset values
  // ----------------------------------------------------------------
  localparam int EXP_HI = 15;
  localparam int EXP_LO = 11;
  localparam int MAN_HI = 10;
  localparam logic [4:0] RAMP_EXP_RST = 5'h1e;
  localparam logic [4:0] LIMIT_EXP_RST = 5'h1f;
  localparam logic [4:0] STOP_EXP_RST = 5'h1f;
  localparam logic [10:0] RAMP_MAN_MIN = 11'h002;
  localparam logic [10:0] RAMP_MAN_MAX = 11'h07f;
  localparam logic [10:0] LIMIT_MAN_MAX = 11'h0fe;
  localparam logic [10:0] STOP_MAN_MAX = 11'h0ff;

  // ----------------------------------------------------------------
  // timeout action byte
  // ----------------------------------------------------------------
  localparam int RESP_HI = 7;
  localparam int RESP_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DLY_HI = 2;
  localparam int DLY_LO = 0;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAYED = 2'h1;
  localparam logic [1:0] RESP_IMMED = 2'h2;
  localparam logic [1:0] RESP_BAD = 2'h3;
  localparam logic [2:0] RETRY_LATCH = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam logic [2:0] DLY_CODE_ZERO = 3'h0;
  localparam logic [2:0] DLY_CODE_ONE = 3'h1;
  localparam logic [2:0] HIC_MULT_ONE = 3'h1;
  localparam logic [2:0] HIC_MULT_TWO = 3'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int QUARTER_MS_NS = 250000;
  localparam int QUARTER_CYC = QUARTER_MS_NS * CLK_MHZ / 1000;
  localparam int STOP_TAIL_US = 50;
  localparam int STOP_TAIL_CYC = STOP_TAIL_US * CLK_MHZ;
  localparam logic [1:0] INIT_SETTLE = 2'h2;

  // ----------------------------------------------------------------
  // sequencer phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_START = 3'b001,
    ST_RAMP = 3'b010,
    ST_RUN = 3'b011,
    ST_FLT_DLY = 3'b100,
    ST_RESTART_WAIT_PERIOD = 3'b101,
    ST_STOP = 3'b110,
    ST_LATCH = 3'b111
  } phase_t;

endpackage

// *** design/tick_gen.sv ***
// quarter-millisecond enable pulse divider with restart
module tick_gen
  import sst_pkg::*;
#(
  parameter int CYCLES = QUARTER_CYC,
  parameter int W = $clog2(CYCLES + 1)
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clr,
  output logic tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } tg_t;

  tg_t s_r;
  tg_t s_nxt;

  // restart keeps phase timing exact from the phase's first cycle
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (clr) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt == W'(CYCLES - 1)) begin
      s_nxt.cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule

// *** design/soft_start_stop_timing_fault.sv ***
// output turn-on / turn-off timing and start-up timeout fault handling
//
// How it works
// R01: ramp setting sets reference slew time
// R02: rise time equals setting, any target voltage
// R03: dac may quantize slope; we pass time
// R04: ramp word: exponent 15:11, mantissa 10:0
// R05: ramp 0..31.75 ms, below 0.5 ms
// R06: out-of-range ramp write flags invalid data
// R07: mantissa from strap; settings apply immediately
// R08: timeout if no 85% within limit
// R09: limit 0..127 ms, exponent resets 11111b
// R10: zero limit disables timeout detection
// R11: undervoltage detection enabled after ramp
// R12: timeout sets three status bits, alerts
// R13: action field: ignore, delayed, immediate
// R14: retry field: latch, 1-6 retries, forever
// R15: delay field sets delay and restart_wait_period
// R16: invalid action byte flags invalid data
// R17: action is byte access, others word
// R18: stop delay until energy transfer stops
// R19: start delay before ramp, window after
// R20: stop delay 0..127.5 ms plus tail
// R21: count retries, clear on successful start
module soft_start_stop_timing_fault
  import sst_pkg::*;
#(
  parameter int QUARTER_CYCLES = QUARTER_CYC,
  parameter int STOP_TAIL_CYCLES = STOP_TAIL_CYC,
  parameter logic [7:0] ACTION_RST = 8'h80,
  parameter logic [10:0] LIMIT_MAN_RST = 11'h000,
  parameter logic [10:0] STOP_MAN_RST = 11'h000
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic on_cmd,
  input wire logic vout_85,
  input wire logic [10:0] ramp_strap,
  input wire logic [7:0] start_delay_half,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_word,
  input wire logic [15:0] cmd_wdata,
  input wire logic clear_faults,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic power_en,
  output logic ramp_active,
  output logic [6:0] ramp_time_q,
  output logic uv_detect_en,
  output logic other_fault_flag,
  output logic vout_word_flag,
  output logic timeout_flag,
  output logic invalid_data,
  output logic host_alert,
  output logic latched_off
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic on_m;
    logic on_s;
    logic vg_m;
    logic vg_s;
    logic [10:0] strap_m;
    logic [10:0] strap_s;
    logic [1:0] init_cnt;
    logic init_done;
    logic [15:0] ramp;
    logic [15:0] limit;
    logic [7:0] action;
    logic [15:0] stop;
    logic [15:0] rd_data;
    logic rd_valid;
    phase_t ph;
    logic [11:0] cnt;
    logic [11:0] wcnt;
    logic [13:0] tcyc;
    logic tail;
    logic reached;
    logic fired;
    logic [2:0] used;
    logic power_en;
    logic ramp_active;
    logic [6:0] ramp_q;
    logic uv_en;
    logic other_fault;
    logic vout_flag;
    logic tmo_flag;
    logic invalid;
    logic alert;
    logic tmo_evt;
    logic latched;
  } st_t;

  st_t s_r;
  st_t s_nxt;
  logic tick;
  logic clr_tick;

  // ----------------------------------------------------------------
  // derived times, all in quarter-millisecond ticks
  // ----------------------------------------------------------------
  logic [10:0] ramp_man;
  logic [6:0] ramp_q;
  logic [8:0] limit_q;
  logic [8:0] stop_q;
  logic [2:0] dly_code;
  logic [4:0] dly_q;
  logic [2:0] hic_mult;
  logic [9:0] hic_q;
  logic [11:0] start_q;
  logic [1:0] resp;
  logic [2:0] retry;

  // short ramps are stretched to the floor value
  assign ramp_man = s_r.ramp[MAN_HI:0];
  assign ramp_q = (ramp_man < RAMP_MAN_MIN) ? RAMP_MAN_MIN[6:0]
                                            : ramp_man[6:0]; // R05
  assign limit_q = {s_r.limit[7:0], 1'b0}; // R09
  assign stop_q = {s_r.stop[7:0], 1'b0}; // R20
  assign start_q = {3'h0, start_delay_half, 1'b0};
  assign resp = s_r.action[RESP_HI:RESP_LO];
  assign retry = s_r.action[RETRY_HI:RETRY_LO];
  assign dly_code = s_r.action[DLY_HI:DLY_LO];
  // code 0 still waits one millisecond
  assign dly_q = {(dly_code == DLY_CODE_ZERO) ? DLY_CODE_ONE : dly_code,
                  2'b00}; // R15
  assign hic_mult = (dly_code == DLY_CODE_ZERO) ? HIC_MULT_ONE :
                    (dly_code == DLY_CODE_ONE) ? HIC_MULT_TWO : dly_code;
  assign hic_q = 10'(ramp_q * hic_mult); // R15

  // the divider restarts with each phase, except across ramp end,
  // where the timeout window keeps running on the same ticks
  assign clr_tick = (s_nxt.ph != s_r.ph) &&
                    !(s_r.ph == ST_RAMP && s_nxt.ph == ST_RUN);

  tick_gen #(
    .CYCLES(QUARTER_CYCLES)
  ) u_tick (
    .clock(clock),
    .nrst(nrst),
    .clr(clr_tick),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_valid = 1'b0;
    s_nxt.tmo_evt = 1'b0;
    // on, 85 percent and strap pins pass two flops before any use
    s_nxt.on_m = on_cmd;
    s_nxt.on_s = s_r.on_m;
    s_nxt.vg_m = vout_85;
    s_nxt.vg_s = s_r.vg_m;
    s_nxt.strap_m = ramp_strap;
    s_nxt.strap_s = s_r.strap_m;

    // strap sampled once the synchroniser has settled
    if (!s_r.init_done) begin
      if (s_r.init_cnt == INIT_SETTLE) begin
        s_nxt.init_done = 1'b1;
        s_nxt.ramp[MAN_HI:0] = s_r.strap_s; // R07
      end else begin
        s_nxt.init_cnt = s_r.init_cnt + 1'b1;
      end
    end

    // clearing first, so an event in the same cycle still sets
    if (clear_faults) begin
      s_nxt.other_fault = 1'b0;
      s_nxt.vout_flag = 1'b0;
      s_nxt.tmo_flag = 1'b0;
      s_nxt.invalid = 1'b0;
    end

    // host writes; a refused write leaves the setting untouched
    if (cmd_wr) begin
      unique case (cmd_code)
        CMD_RAMP: begin
          if (cmd_word && cmd_wdata[EXP_HI:EXP_LO] == RAMP_EXP_RST &&
              cmd_wdata[MAN_HI:0] <= RAMP_MAN_MAX) begin
            s_nxt.ramp = cmd_wdata; // R04
          end else begin
            s_nxt.invalid = 1'b1; // R06
          end
        end
        CMD_LIMIT: begin
          if (cmd_word && cmd_wdata[EXP_HI:EXP_LO] == LIMIT_EXP_RST &&
              cmd_wdata[MAN_HI:0] <= LIMIT_MAN_MAX) begin
            s_nxt.limit = cmd_wdata; // R09
          end else begin
            s_nxt.invalid = 1'b1;
          end
        end
        CMD_ACTION: begin
          if (!cmd_word && cmd_wdata[RESP_HI:RESP_LO] != RESP_BAD) begin
            s_nxt.action = cmd_wdata[7:0]; // R17
          end else begin
            s_nxt.invalid = 1'b1; // R16
          end
        end
        CMD_STOP: begin
          if (cmd_word && cmd_wdata[EXP_HI:EXP_LO] == STOP_EXP_RST &&
              cmd_wdata[MAN_HI:0] <= STOP_MAN_MAX) begin
            s_nxt.stop = cmd_wdata; // R20
          end else begin
            s_nxt.invalid = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // reads answer the next cycle; other codes belong elsewhere
    if (cmd_rd) begin
      unique case (cmd_code)
        CMD_RAMP, CMD_LIMIT, CMD_STOP: begin
          s_nxt.rd_valid = cmd_word; // R17
          s_nxt.invalid = s_nxt.invalid | !cmd_word;
          s_nxt.rd_data = (cmd_code == CMD_RAMP) ? s_r.ramp :
                          (cmd_code == CMD_LIMIT) ? s_r.limit : s_r.stop;
        end
        CMD_ACTION: begin
          s_nxt.rd_valid = !cmd_word;
          s_nxt.invalid = s_nxt.invalid | cmd_word;
          s_nxt.rd_data = {8'h00, s_r.action};
        end
        default: ;
      endcase
    end

    // slew setting follows the register on the fly, ramping or not
    s_nxt.ramp_q = ramp_q; // R01 R02 R03 R07

    // phase timers advance on the quarter-millisecond enable
    if (tick) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end

    // timeout window runs from end of start delay until 85 percent
    if ((s_r.ph == ST_RAMP || s_r.ph == ST_RUN) && !s_r.reached) begin
      if (s_r.vg_s) begin
        s_nxt.reached = 1'b1;
        s_nxt.used = '0; // R21
      end else begin
        if (tick) begin
          s_nxt.wcnt = s_r.wcnt + 1'b1; // R08
        end
        if (limit_q != '0 && !s_r.fired &&
            s_r.wcnt >= 12'(limit_q)) begin // R10
          s_nxt.fired = 1'b1;
          s_nxt.tmo_evt = 1'b1; // R08
          s_nxt.other_fault = 1'b1; // R12
          s_nxt.vout_flag = 1'b1;
          s_nxt.tmo_flag = 1'b1;
          unique case (resp)
            RESP_DELAYED: begin
              s_nxt.ph = ST_FLT_DLY; // R13
              s_nxt.cnt = '0;
            end
            RESP_IMMED: begin
              s_nxt.ph = ST_RESTART_WAIT_PERIOD; // R13
            end
            default: ;
          endcase
        end
      end
    end

    unique case (s_r.ph)
      ST_OFF: begin
        if (s_r.on_s) begin
          s_nxt.ph = ST_START; // R19
          s_nxt.cnt = '0;
          s_nxt.used = '0;
        end
      end
      ST_START: begin
        if (s_r.cnt >= start_q) begin
          s_nxt.ph = ST_RAMP; // R19
          s_nxt.cnt = '0;
          s_nxt.wcnt = '0;
          s_nxt.fired = 1'b0;
          s_nxt.reached = 1'b0;
          s_nxt.power_en = 1'b1;
          s_nxt.ramp_active = 1'b1;
        end
      end
      ST_RAMP: begin
        // dac slews target over ramp time, so rise time is fixed
        if (s_r.cnt >= 12'(ramp_q) && s_nxt.ph == ST_RAMP) begin
          s_nxt.ph = ST_RUN;
          s_nxt.ramp_active = 1'b0;
          s_nxt.uv_en = 1'b1; // R11
        end
      end
      ST_RUN: ;
      ST_FLT_DLY: begin
        if (s_r.vg_s) begin
          s_nxt.ph = ST_RUN;
          s_nxt.reached = 1'b1;
          s_nxt.used = '0; // R21
        end else if (s_r.cnt >= 12'(dly_q)) begin
          s_nxt.ph = ST_RESTART_WAIT_PERIOD; // R13
        end
      end
      ST_RESTART_WAIT_PERIOD: begin
        if (s_r.cnt >= 12'(hic_q)) begin
          s_nxt.ph = ST_START; // R14
          s_nxt.cnt = '0;
        end
      end
      ST_STOP: begin
        // stop delay, then the fixed internal tail, then off
        if (!s_r.tail) begin
          if (s_r.cnt >= 12'(stop_q)) begin
            s_nxt.tail = 1'b1; // R18
            s_nxt.tcyc = '0;
          end
        end else if (s_r.tcyc >= 14'(STOP_TAIL_CYCLES - 1)) begin
          s_nxt.ph = ST_OFF; // R20
          s_nxt.tail = 1'b0;
          s_nxt.power_en = 1'b0;
          s_nxt.ramp_active = 1'b0;
          s_nxt.uv_en = 1'b0;
        end else begin
          s_nxt.tcyc = s_r.tcyc + 1'b1;
        end
      end
      ST_LATCH: begin
        if (!s_r.on_s) begin
          s_nxt.ph = ST_OFF; // R14
          s_nxt.used = '0;
        end
      end
    endcase

    // shutdown: decide between restart wait and latch-off
    if (s_nxt.ph == ST_RESTART_WAIT_PERIOD && s_r.ph != ST_RESTART_WAIT_PERIOD) begin
      s_nxt.power_en = 1'b0;
      s_nxt.ramp_active = 1'b0;
      s_nxt.uv_en = 1'b0;
      s_nxt.cnt = '0;
      if (retry == RETRY_LATCH ||
          (retry != RETRY_FOREVER && s_r.used >= retry)) begin
        s_nxt.ph = ST_LATCH; // R14
      end else if (retry != RETRY_FOREVER) begin
        s_nxt.used = s_r.used + 1'b1; // R21
      end
    end

    // stop condition overrides any running phase
    if (!s_r.on_s && s_r.ph != ST_OFF && s_r.ph != ST_STOP &&
        s_r.ph != ST_LATCH) begin
      s_nxt.ph = ST_STOP; // R18
      s_nxt.cnt = '0;
      s_nxt.tail = 1'b0;
    end

    s_nxt.alert = s_nxt.other_fault | s_nxt.invalid; // R12
    // registered copy so the pin never shows a decode glitch
    s_nxt.latched = (s_nxt.ph == ST_LATCH); // R14
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.ramp <= {RAMP_EXP_RST, RAMP_MAN_MIN}; // R04
      s_r.limit <= {LIMIT_EXP_RST, LIMIT_MAN_RST}; // R09
      s_r.action <= ACTION_RST;
      s_r.stop <= {STOP_EXP_RST, STOP_MAN_RST};
      s_r.ph <= ST_OFF;
      s_r.ramp_q <= RAMP_MAN_MIN[6:0];
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign rd_data = s_r.rd_data;
  assign rd_valid = s_r.rd_valid;
  assign power_en = s_r.power_en;
  assign ramp_active = s_r.ramp_active;
  assign ramp_time_q = s_r.ramp_q;
  assign uv_detect_en = s_r.uv_en;
  assign other_fault_flag = s_r.other_fault;
  assign vout_word_flag = s_r.vout_flag;
  assign timeout_flag = s_r.tmo_flag;
  assign invalid_data = s_r.invalid;
  assign host_alert = s_r.alert;
  assign latched_off = s_r.latched;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ramp_floor: assert property ( // R05
    @(posedge clock) disable iff (!nrst)
    s_r.ramp_q >= RAMP_MAN_MIN[6:0])
    else $error("ramp time below floor");

  a_uv_after_ramp: assert property ( // R11
    @(posedge clock) disable iff (!nrst)
    $rose(s_r.uv_en) |-> $past(s_r.ph) == ST_RAMP && s_r.ph == ST_RUN)
    else $error("uv detection enabled outside ramp end");

  a_fault_flags: assert property ( // R12
    @(posedge clock) disable iff (!nrst)
    s_r.tmo_evt |-> s_r.other_fault && s_r.vout_flag && s_r.tmo_flag
      ##1 s_r.alert)
    else $error("timeout did not set status bits");

  a_bad_action: assert property ( // R16
    @(posedge clock) disable iff (!nrst)
    cmd_wr && cmd_code == CMD_ACTION &&
      cmd_wdata[RESP_HI:RESP_LO] == RESP_BAD
      |=> s_r.invalid && s_r.action == $past(s_r.action))
    else $error("invalid action byte accepted");

  a_limit_off: assert property ( // R10
    @(posedge clock) disable iff (!nrst)
    s_r.limit[7:0] == 8'h00 |=> !s_r.tmo_evt)
    else $error("timeout raised with zero limit");

  a_immed_shut: assert property ( // R13
    @(posedge clock) disable iff (!nrst)
    s_r.tmo_evt && resp == RESP_IMMED && s_r.on_s
      |-> !s_r.power_en)
    else $error("immediate response kept power on");

  a_latch_zero: assert property ( // R14
    @(posedge clock) disable iff (!nrst)
    $rose(s_r.ph == ST_RESTART_WAIT_PERIOD) |-> $past(retry) != RETRY_LATCH)
    else $error("restart wait with retries disabled");

  a_ramp_store: assert property ( // R04
    @(posedge clock) disable iff (!nrst)
    cmd_wr && cmd_word && cmd_code == CMD_RAMP &&
      cmd_wdata[EXP_HI:EXP_LO] == RAMP_EXP_RST &&
      cmd_wdata[MAN_HI:0] <= RAMP_MAN_MAX
      |=> s_r.ramp == $past(cmd_wdata))
    else $error("valid ramp write not stored");

  a_success_clear: assert property ( // R21
    @(posedge clock) disable iff (!nrst)
    $rose(s_r.reached) |-> s_r.used == 3'h0)
    else $error("retry count kept after good start");

endmodule

// *** dv/vout_plant.sv ***
// output voltage model standing behind the sense comparator
module vout_plant (
  input wire logic link_clk,
  input wire logic power_en,
  input wire logic ramp_active,
  input wire logic stuck_low,
  output logic vout_85
);
  timeunit 1ns;
  timeprecision 1ps;
  initial vout_85 = 1'b0;
  // output climbs past 85% only once the ramp is over; a stuck output
  // never does, which is how the bench provokes a start-up timeout
  always @(posedge link_clk or negedge power_en) begin
    if (!power_en || stuck_low) begin
      vout_85 <= 1'b0;
    end else if (!ramp_active) begin
      vout_85 <= 1'b1;
    end
  end
endmodule

// *** dv/soft_start_stop_timing_fault_tb_top.sv ***
// self-checking bench for the soft-start / stop timing block
module soft_start_stop_timing_fault_tb_top;
  import sst_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // shortened tick and tail keep the run brief
  localparam int T = 20;
  localparam int TAIL = 5;
  logic clock = 0, nrst = 0, on_cmd = 0, link_clk = 0, stuck_low = 0;
  logic cmd_wr = 0, cmd_rd = 0, cmd_word = 0, clear_faults = 0;
  logic [10:0] ramp_strap = 11'h008;
  logic [7:0] start_delay_half = 8'h00, cmd_code = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000, rd_data;
  logic [6:0] ramp_time_q;
  logic vout_85, rd_valid, power_en, ramp_active, uv_detect_en;
  logic other_fault_flag, vout_word_flag, timeout_flag, invalid_data;
  logic host_alert, latched_off;
  int fail_count = 0, num_checks = 0, cycles = 0, n;

  // ----------------------------------------------------------------
  // clocks, design and output model
  // ----------------------------------------------------------------
  always #2.5 clock = ~clock;
  // link clock offset so its edges drift against the system clock
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  soft_start_stop_timing_fault #(.QUARTER_CYCLES(T),
    .STOP_TAIL_CYCLES(TAIL)) soft_start_stop_timing_fault_inst (
    .clock(clock), .nrst(nrst), .on_cmd(on_cmd), .vout_85(vout_85),
    .ramp_strap(ramp_strap), .start_delay_half(start_delay_half),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_word(cmd_word), .cmd_wdata(cmd_wdata),
    .clear_faults(clear_faults), .rd_data(rd_data), .rd_valid(rd_valid),
    .power_en(power_en), .ramp_active(ramp_active),
    .ramp_time_q(ramp_time_q), .uv_detect_en(uv_detect_en),
    .other_fault_flag(other_fault_flag), .vout_word_flag(vout_word_flag),
    .timeout_flag(timeout_flag), .invalid_data(invalid_data),
    .host_alert(host_alert), .latched_off(latched_off));

  vout_plant vout_plant_inst (.link_clk(link_clk), .power_en(power_en),
    .ramp_active(ramp_active), .stuck_low(stuck_low), .vout_85(vout_85));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic step();
    @(posedge clock);
    #1;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // cycle counts are judged with a small window for synchroniser slack
  task automatic check_near(input int got, input int exp, input int tol);
    num_checks++;
    if (got < exp - tol || got > exp + tol) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] c, input logic w, input logic [15:0] d);
    @(posedge clock);
    cmd_wr <= 1'b1;
    cmd_code <= c;
    cmd_word <= w;
    cmd_wdata <= d;
    @(posedge clock);
    cmd_wr <= 1'b0;
    step();
  endtask

  task automatic rd(input logic [7:0] c, input logic w, input logic v,
                    input logic [15:0] exp);
    @(posedge clock);
    cmd_rd <= 1'b1;
    cmd_code <= c;
    cmd_word <= w;
    @(posedge clock);
    cmd_rd <= 1'b0;
    #1;
    check(rd_valid, v);
    if (v) check(rd_data, exp);
  endtask

  task automatic clear();
    @(posedge clock);
    clear_faults <= 1'b1;
    @(posedge clock);
    clear_faults <= 1'b0;
    step();
    step();
  endtask

  // drop the start condition and wait until fully off
  task automatic off_wait();
    @(posedge clock);
    on_cmd <= 1'b0;
    n = 0;
    while ((power_en || latched_off) && n < 2000) begin step(); n++; end
    check(latched_off, 1'b0);
    clear();
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    rd(CMD_RAMP, 1'b1, 1'b1, 16'hf008);
    rd(CMD_LIMIT, 1'b1, 1'b1, 16'hf800);
    rd(CMD_ACTION, 1'b0, 1'b1, 16'h0080);
    rd(CMD_STOP, 1'b1, 1'b1, 16'hf800);
    check(ramp_time_q, 7'h08);
  endtask

  task automatic t_refusals();
    logic [24:0] bad [7] = '{{8'h61, 1'b1, 16'hf080}, {8'h61, 1'b1, 16'he804},
      {8'h61, 1'b0, 16'h0004}, {8'h62, 1'b1, 16'hf8ff},
      {8'h63, 1'b0, 16'h00c0}, {8'h63, 1'b1, 16'h0008},
      {8'h64, 1'b1, 16'hf900}};
    wr(CMD_RAMP, 1'b1, 16'hf001);
    check(ramp_time_q, 7'h02);
    rd(CMD_RAMP, 1'b1, 1'b1, 16'hf001);
    wr(CMD_RAMP, 1'b1, 16'hf07f);
    check(ramp_time_q, 7'h7f);
    check(invalid_data, 1'b0);
    for (int i = 0; i < 7; i++) begin
      wr(bad[i][24:17], bad[i][16], bad[i][15:0]);
      step();
      check(invalid_data, 1'b1);
      check(host_alert, 1'b1);
      clear();
      check(invalid_data, 1'b0);
    end
    rd(CMD_RAMP, 1'b1, 1'b1, 16'hf07f);
    rd(CMD_ACTION, 1'b0, 1'b1, 16'h0080);
    rd(CMD_LIMIT, 1'b0, 1'b0, 16'h0000);
    step();
    check(invalid_data, 1'b1);
    clear();
  endtask

  task automatic t_start_stop();
    wr(CMD_RAMP, 1'b1, 16'hf004);
    wr(CMD_LIMIT, 1'b1, 16'hf810);
    wr(CMD_STOP, 1'b1, 16'hf801);
    @(posedge clock);
    start_delay_half <= 8'h01;
    on_cmd <= 1'b1;
    n = 0;
    while (!power_en && n < 2000) begin step(); n++; end
    check_near(n, 2 * T + 3, 3);
    check(ramp_active, 1'b1);
    check(uv_detect_en, 1'b0);
    n = 0;
    while (ramp_active && n < 2000) begin step(); n++; end
    check_near(n, 4 * T, 2);
    step();
    check(uv_detect_en, 1'b1);
    repeat (40 * T) step();
    check(timeout_flag, 1'b0);
    check(power_en, 1'b1);
    @(posedge clock);
    on_cmd <= 1'b0;
    start_delay_half <= 8'h00;
    n = 0;
    while (power_en && n < 2000) begin step(); n++; end
    check_near(n, 2 * T + TAIL + 3, 4);
    clear();
  endtask

  task automatic t_timeout_actions();
    logic [7:0] act [4] = '{8'h88, 8'h41, 8'h00, 8'hb9};
    logic saw;
    wr(CMD_LIMIT, 1'b1, 16'hf801);
    stuck_low <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(CMD_ACTION, 1'b0, {8'h00, act[i]});
      @(posedge clock);
      on_cmd <= 1'b1;
      n = 0;
      while (!timeout_flag && n < 500) begin step(); n++; end
      check_near(n, 2 * T + 4, 6);
      check(other_fault_flag, 1'b1);
      check(vout_word_flag, 1'b1);
      step();
      check(host_alert, 1'b1);
      if (i == 0) begin
        check(power_en, 1'b0);
        saw = 1'b0;
        n = 0;
        while (!latched_off && n < 2000) begin
          step();
          n++;
          if (power_en) saw = 1'b1;
        end
        check(saw, 1'b1);
        check(latched_off, 1'b1);
      end else if (i == 1) begin
        repeat (2 * T) step();
        check(power_en, 1'b1);
        n = 2 * T + 1;
        while (power_en && n < 500) begin step(); n++; end
        check_near(n, 4 * T, 4);
        step();
        check(latched_off, 1'b1);
      end else if (i == 2) begin
        repeat (4 * T) step();
        check(power_en, 1'b1);
      end else begin
        // endless retries: well past six restarts, never latched
        repeat (80 * T) step();
        check(latched_off, 1'b0);
      end
      off_wait();
    end
    wr(CMD_LIMIT, 1'b1, 16'hf800);
    @(posedge clock);
    on_cmd <= 1'b1;
    repeat (10 * T) step();
    check(timeout_flag, 1'b0);
    check(power_en, 1'b1);
    off_wait();
    stuck_low <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard; the full run needs well under a fifth of this
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (6) step();
    t_reset_values();
    t_refusals();
    t_start_stop();
    t_timeout_actions();
    print_verdict();
  end
endmodule
